// ---- src/ohi_pkg.sv ----
// Shared types, pin positions and timing for both ends of the display host port.
// Assumes the host runs at 50 MHz and the display end on the link clock made by the host.
package ohi_pkg;
  typedef enum logic [1:0] {OHI_M6800, OHI_M8080, OHI_MSPI, OHI_MI2C} ohi_mode_e;
  typedef enum logic [1:0] {OHI_I_IDLE, OHI_I_ADDR, OHI_I_CTRL, OHI_I_DATA} ohi_i2c_e;

  // Strap codes {second, first}; adjust to the controller in use
  localparam logic [1:0] STRAP_6800 = 2'h0;
  localparam logic [1:0] STRAP_8080 = 2'h1;
  localparam logic [1:0] STRAP_SPI  = 2'h2;
  localparam logic [1:0] STRAP_I2C  = 2'h3;

  // Positions in the sampled pin vector of the display end
  localparam int PIN_CS  = 8;
  localparam int PIN_DC  = 9;
  localparam int PIN_RW  = 10;
  localparam int PIN_E   = 11;
  localparam int PIN_BS1 = 12;
  localparam int PIN_BS2 = 13;
  localparam int PIN_W   = 14;

  // Upper six address bits of the two-wire slave; value is arbitrary
  localparam logic [5:0] I2C_ADDR_HI = 6'h2a;
  localparam int         CTRL_CO     = 7;
  localparam int         CTRL_DC     = 6;
  localparam logic [3:0] SPI_LAST    = 4'h7;
  localparam logic [3:0] I2C_LAST    = 4'h8;
  localparam logic [3:0] I2C_ACK_END = 4'h9;

  // Data-line enables (low = driven) and levels
  localparam logic [7:0] OE_NONE     = 8'hff;
  localparam logic [7:0] OE_IDLE_SPI = 8'h04;
  localparam logic [7:0] OE_IDLE_I2C = 8'h06;
  localparam logic [7:0] DRV_IDL_I2C = 8'h01;

  // Timing
  localparam int         CLK_NS    = 20;
  localparam logic [2:0] LINK_HALF = 3'h4;
  localparam int         STEP_NS   = 1000;
  localparam int         RESET_NS  = 3000;
  localparam logic [7:0] STEP_CYC  = 8'((STEP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RESET_CYC = 8'((RESET_NS + CLK_NS - 1) / CLK_NS);

  function automatic ohi_mode_e ohi_decode(input logic [1:0] bs);
    ohi_mode_e m;
    m = OHI_M6800;
    if (bs == STRAP_8080) m = OHI_M8080;
    else if (bs == STRAP_SPI) m = OHI_MSPI;
    else if (bs == STRAP_I2C) m = OHI_MI2C;
    return m;
  endfunction

  function automatic logic [1:0] ohi_encode(input ohi_mode_e m);
    logic [1:0] bs;
    bs = STRAP_6800;
    if (m == OHI_M8080) bs = STRAP_8080;
    else if (m == OHI_MSPI) bs = STRAP_SPI;
    else if (m == OHI_MI2C) bs = STRAP_I2C;
    return bs;
  endfunction
endpackage

// ---- src/ohi_link_if.sv ----
// Pins between the host and the display end.
// Data lines are resolved here as a wired-AND; an undriven line reads high.
`timescale 1ns/1ps
interface ohi_link_if;
  logic       link_clk;
  logic       power_on_clear_n;
  logic       chip_sel_n;
  logic       data_cmd_sel;
  logic       strobe_e_rd;
  logic       strobe_rw_wr;
  logic       bus_select_first;
  logic       bus_select_second;
  logic [7:0] host_drive;
  logic [7:0] host_oe_n;
  logic [7:0] dev_drive;
  logic [7:0] dev_oe_n;
  logic [7:0] host_data_lines;

  assign host_data_lines = (host_drive | host_oe_n) & (dev_drive | dev_oe_n);

  modport host (
    output link_clk, power_on_clear_n, chip_sel_n, data_cmd_sel, strobe_e_rd,
    output strobe_rw_wr, bus_select_first, bus_select_second, host_drive, host_oe_n,
    input  host_data_lines
  );
  modport dev (
    input  link_clk, power_on_clear_n, chip_sel_n, data_cmd_sel, strobe_e_rd,
    input  strobe_rw_wr, bus_select_first, bus_select_second, host_data_lines,
    output dev_drive, dev_oe_n
  );
endinterface

// ---- src/ohi_device.sv ----
// Display end of the host port: decodes parallel, serial and two-wire transfers.
// Pin logic runs on the link clock; bytes reach the controller core on clk.
`timescale 1ns/1ps
// How it works
// (RL1) Low reset pin initializes; host keeps it high
// (RL2) Transfers honoured only while chip select low
// (RL3) Parallel byte: data if select high, else command
// (RL4) Serial byte: data if select high, else command
// (RL5) Two-wire: select pin is slave address bit
// (RL6) Enable-strobe mode: enable high starts access
// (RL7) Enable-strobe mode: direction high read, low write
// (RL8) Separate strobes: read strobe low starts read
// (RL9) Separate strobes: write strobe low starts write
// (RL10) Parallel data lines: sampled on write, driven read
// (RL11) Serial: line 1 data, line 0 clock
// (RL12) Two-wire: lines 2,1 tied SDA, line 0 SCL
// (RL13) Host grounds unused data lines, serial line 2 excepted
// (RL14) Serial/two-wire: both strobe pins tied low
// (RL15) Interface type chosen from the two straps
// (RL16) Straps static; level mapping set in package
module ohi_device (
  // Link side
  ohi_link_if.dev           link,
  // Core side
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [7:0]   read_byte,
  input  wire logic         read_load,
  output logic              out_valid,
  output logic [7:0]        out_byte,
  output logic              out_is_data,
  output logic              core_init,
  output ohi_pkg::ohi_mode_e mode
);
  import ohi_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] pin_a;
    logic [PIN_W-1:0] pin_b;
    logic [PIN_W-1:0] pin_prev;
    logic             ce_a;
    logic             ce_b;
    logic             rt_a;
    logic             rt_b;
    logic             rt_seen;
    logic [7:0]       rd_byte;
    logic [1:0]       strap_cnt;
    ohi_mode_e        mode;
    logic             acc;
    logic [7:0]       shift;
    logic [3:0]       bitn;
    ohi_i2c_e         ph;
    logic             i2c_dc;
    logic             i2c_co;
    logic [7:0]       wr_byte;
    logic             wr_dc;
    logic             wr_tg;
    logic [7:0]       drv;
    logic [7:0]       oe_n;
  } ohi_dlk_s;

  typedef struct packed {
    logic       tg_a;
    logic       tg_b;
    logic       tg_seen;
    logic       init_a;
    logic       init_b;
    ohi_mode_e  md_a;
    ohi_mode_e  md_b;
    logic       out_valid;
    logic [7:0] out_byte;
    logic       out_is_data;
    logic       core_init;
    ohi_mode_e  mode;
    logic [7:0] rd_hold;
    logic       rd_tg;
  } ohi_dck_s;

  ohi_dlk_s         lq;
  ohi_dlk_s         next_lq;
  ohi_dck_s         cq;
  ohi_dck_s         next_cq;
  logic             lrst;
  logic [PIN_W-1:0] cur;
  logic [PIN_W-1:0] prv;
  logic [PIN_W-1:0] up;
  logic [PIN_W-1:0] dn;
  logic             sel;
  logic             emit;
  logic             rd_drive;
  logic [7:0]       ebyte;
  logic             edc;

  // The pin reset acts asynchronously, so a glitch on it clears the link state
  assign lrst = rst | ~link.power_on_clear_n; // RL1
  assign cur  = lq.pin_b;
  assign prv  = lq.pin_prev;
  assign up   = cur & ~prv;
  assign dn   = ~cur & prv;
  assign sel  = ~cur[PIN_CS];

  always_comb begin
    next_lq  = lq;
    emit     = 1'b0;
    rd_drive = 1'b0;
    ebyte    = 8'h00;
    edc      = 1'b0;
    next_lq.pin_a = {link.bus_select_second, link.bus_select_first, link.strobe_e_rd,
                     link.strobe_rw_wr, link.data_cmd_sel, link.chip_sel_n,
                     link.host_data_lines};
    next_lq.pin_b = lq.pin_a;
    next_lq.ce_a  = ce;
    next_lq.ce_b  = lq.ce_a;
    next_lq.rt_a  = cq.rd_tg;
    next_lq.rt_b  = lq.rt_a;
    if (lq.ce_b) begin
      next_lq.pin_prev = lq.pin_b;
      if (lq.rt_b != lq.rt_seen) begin
        next_lq.rt_seen = lq.rt_b;
        next_lq.rd_byte = cq.rd_hold;
      end
      if (lq.strap_cnt != 2'h3) begin
        next_lq.strap_cnt = lq.strap_cnt + 2'h1;
        // Straps are read once, after the synchroniser has filled
        if (lq.strap_cnt == 2'h2) next_lq.mode = ohi_decode(cur[PIN_BS2:PIN_BS1]); // RL15 RL16
      end else begin
        unique case (lq.mode)
          OHI_M6800: begin
            if (up[PIN_E] && sel) next_lq.acc = 1'b1; // RL6 RL2
            if (cur[PIN_E] && sel && cur[PIN_RW] && lq.acc) rd_drive = 1'b1; // RL7 RL10
            if (dn[PIN_E]) begin
              next_lq.acc = 1'b0;
              if (lq.acc && !prv[PIN_RW] && !prv[PIN_CS]) begin // RL7
                emit  = 1'b1;
                ebyte = prv[7:0]; // RL10
                edc   = prv[PIN_DC]; // RL3
              end
            end
          end
          OHI_M8080: begin
            if (!cur[PIN_E] && sel) rd_drive = 1'b1; // RL8 RL10
            if (dn[PIN_RW] && sel) next_lq.acc = 1'b1; // RL9 RL2
            if (up[PIN_RW]) begin
              next_lq.acc = 1'b0;
              if (lq.acc) begin
                emit  = 1'b1;
                ebyte = prv[7:0]; // RL10
                edc   = prv[PIN_DC]; // RL3
              end
            end
          end
          OHI_MSPI: begin
            if (!sel) begin
              next_lq.bitn = 4'h0; // RL2
            end else if (up[0]) begin // RL11
              next_lq.shift = {lq.shift[6:0], cur[1]};
              if (lq.bitn == SPI_LAST) begin
                next_lq.bitn = 4'h0;
                emit  = 1'b1;
                ebyte = {lq.shift[6:0], cur[1]};
                edc   = cur[PIN_DC]; // RL4
              end else begin
                next_lq.bitn = lq.bitn + 4'h1;
              end
            end
          end
          OHI_MI2C: begin
            // SCL on line 0, SDA sensed on line 1, acknowledge driven on line 2
            if (!sel) begin // RL2
              next_lq.ph      = OHI_I_IDLE;
              next_lq.oe_n[2] = 1'b1;
            end else if (cur[0] && prv[0] && dn[1]) begin // RL12
              next_lq.ph      = OHI_I_ADDR;
              next_lq.bitn    = 4'h0;
              next_lq.oe_n[2] = 1'b1;
            end else if (cur[0] && prv[0] && up[1]) begin
              next_lq.ph      = OHI_I_IDLE;
              next_lq.oe_n[2] = 1'b1;
            end else if (lq.ph != OHI_I_IDLE) begin
              if (up[0] && lq.bitn < I2C_LAST) begin
                next_lq.shift = {lq.shift[6:0], cur[1]};
                next_lq.bitn  = lq.bitn + 4'h1;
              end else if (dn[0] && lq.bitn == I2C_LAST) begin
                next_lq.bitn    = I2C_ACK_END;
                next_lq.oe_n[2] = 1'b0;
                unique case (lq.ph)
                  OHI_I_ADDR: begin
                    // Only a write to our address is acknowledged
                    if (lq.shift == {I2C_ADDR_HI, cur[PIN_DC], 1'b0}) begin // RL5
                      next_lq.ph = OHI_I_CTRL;
                    end else begin
                      next_lq.ph      = OHI_I_IDLE;
                      next_lq.oe_n[2] = 1'b1;
                    end
                  end
                  OHI_I_CTRL: begin
                    next_lq.i2c_dc = lq.shift[CTRL_DC];
                    next_lq.i2c_co = lq.shift[CTRL_CO];
                    next_lq.ph     = OHI_I_DATA;
                  end
                  OHI_I_DATA: begin
                    emit  = 1'b1;
                    ebyte = lq.shift;
                    edc   = lq.i2c_dc;
                    if (lq.i2c_co) next_lq.ph = OHI_I_CTRL;
                  end
                  OHI_I_IDLE: next_lq.ph = OHI_I_IDLE;
                endcase
              end else if (dn[0] && lq.bitn == I2C_ACK_END) begin
                next_lq.bitn    = 4'h0;
                next_lq.oe_n[2] = 1'b1;
              end
            end
          end
        endcase
      end
      if (lq.mode != OHI_MI2C) begin
        next_lq.drv  = lq.rd_byte;
        next_lq.oe_n = rd_drive ? 8'h00 : OE_NONE; // RL10
      end
      if (emit) begin
        next_lq.wr_byte = ebyte;
        next_lq.wr_dc   = edc;
        next_lq.wr_tg   = ~lq.wr_tg;
      end
    end
  end

  always_ff @(posedge link.link_clk or posedge lrst) begin
    if (lrst) begin
      lq      <= '0;
      lq.oe_n <= OE_NONE;
    end else begin
      lq <= next_lq;
    end
  end

  // Core side: bytes cross by toggle; the link holds each byte until the next one
  always_comb begin
    next_cq        = cq;
    next_cq.tg_a   = lq.wr_tg;
    next_cq.tg_b   = cq.tg_a;
    next_cq.init_a = ~link.power_on_clear_n;
    next_cq.init_b = cq.init_a;
    next_cq.md_a   = lq.mode;
    next_cq.md_b   = cq.md_a;
    if (ce) begin
      next_cq.out_valid = 1'b0;
      next_cq.core_init = cq.init_b; // RL1
      next_cq.mode      = cq.md_b;
      if (cq.tg_b != cq.tg_seen) begin
        next_cq.tg_seen     = cq.tg_b;
        next_cq.out_valid   = 1'b1;
        next_cq.out_byte    = lq.wr_byte;
        next_cq.out_is_data = lq.wr_dc; // RL3 RL4
      end
      if (read_load) begin
        next_cq.rd_hold = read_byte;
        next_cq.rd_tg   = ~cq.rd_tg;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cq <= '0;
    end else begin
      cq <= next_cq;
    end
  end

  assign out_valid     = cq.out_valid;
  assign out_byte      = cq.out_byte;
  assign out_is_data   = cq.out_is_data;
  assign core_init     = cq.core_init;
  assign mode          = cq.mode;
  assign link.dev_drive = lq.drv;
  assign link.dev_oe_n  = lq.oe_n;
endmodule

// ---- src/ohi_host.sv ----
// Host end of the display port: turns byte requests into pin sequences.
// Makes the link clock by dividing clk; pins change on STEP_CYC boundaries.
`timescale 1ns/1ps
module ohi_host (
  // Link side
  ohi_link_if.host          link,
  // User side
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  ohi_pkg::ohi_mode_e mode_sel,
  input  wire logic         sa0_sel,
  input  wire logic         req_valid,
  input  wire logic         req_write,
  input  wire logic         req_is_data,
  input  wire logic [7:0]   req_byte,
  output logic              req_ready,
  output logic              resp_valid,
  output logic [7:0]        resp_byte
);
  import ohi_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_STROBE, H_RECOVER, H_BIT_LO, H_BIT_DAT, H_BIT_HI
  } ohi_hst_e;

  typedef struct packed {
    logic [2:0]  dcnt;
    logic        lclk;
    logic [7:0]  por_cnt;
    logic        por_n;
    logic        strap_done;
    ohi_mode_e   mode;
    logic [1:0]  bs;
    ohi_hst_e    st;
    logic [7:0]  tmr;
    logic        wr;
    logic [8:0]  shift;
    logic [3:0]  bitn;
    logic [1:0]  left;
    logic        stopping;
    logic [15:0] queue;
    logic [7:0]  din_a;
    logic [7:0]  din_b;
    logic        ready;
    logic        resp_valid;
    logic [7:0]  resp_byte;
    logic        cs_n;
    logic        dc;
    logic        e_rd;
    logic        rw_wr;
    logic [7:0]  drv;
    logic [7:0]  oe_n;
  } ohi_hq_s;

  ohi_hq_s q;
  ohi_hq_s next_q;
  logic    par;
  logic    i2c;

  assign par = (q.mode == OHI_M6800) || (q.mode == OHI_M8080);
  assign i2c = (q.mode == OHI_MI2C);

  always_comb begin
    next_q       = q;
    next_q.din_a = link.host_data_lines;
    next_q.din_b = q.din_a;
    if (ce) begin
      next_q.resp_valid = 1'b0;
      if (q.dcnt == LINK_HALF - 3'h1) begin
        next_q.dcnt = 3'h0;
        next_q.lclk = ~q.lclk;
      end else begin
        next_q.dcnt = q.dcnt + 3'h1;
      end
      if (!q.strap_done) begin
        next_q.strap_done = 1'b1;
        next_q.mode       = mode_sel;
        next_q.bs         = ohi_encode(mode_sel); // RL15 RL16
      end
      // Reset pin stays low for RESET_CYC after rst, then high for good
      if (!q.por_n) begin
        if (q.por_cnt == RESET_CYC) next_q.por_n = 1'b1; // RL1
        else next_q.por_cnt = q.por_cnt + 8'h01;
      end
      if (q.tmr != 8'h00) begin
        next_q.tmr = q.tmr - 8'h01;
      end else begin
        next_q.tmr = STEP_CYC;
        unique case (q.st)
          H_IDLE: begin
            next_q.tmr   = 8'h00;
            next_q.cs_n  = ~i2c;
            next_q.e_rd  = (q.mode == OHI_M8080); // RL14
            next_q.rw_wr = (q.mode == OHI_M8080); // RL14
            next_q.drv   = i2c ? DRV_IDL_I2C : 8'h00; // RL13
            next_q.oe_n  = i2c ? OE_IDLE_I2C : (q.mode == OHI_MSPI) ? OE_IDLE_SPI : 8'h00;
            next_q.ready = q.por_n && q.strap_done;
            if (req_valid && q.ready) begin
              next_q.ready = 1'b0;
              next_q.wr    = req_write;
              next_q.bitn  = 4'h0;
              // A full step before the next pin change, so the link sampler sees them in order
              next_q.tmr   = STEP_CYC;
              if (!req_write && !par) begin
                // Serial links are write-only here: answer with zero
                next_q.resp_valid = 1'b1;
                next_q.resp_byte  = 8'h00;
                next_q.tmr        = 8'h00;
              end else if (par) begin
                next_q.st   = H_SETUP;
                next_q.cs_n = 1'b0;
                next_q.dc   = req_is_data; // RL3
                next_q.drv  = req_byte;
                next_q.oe_n = req_write ? 8'h00 : OE_NONE;
                if (q.mode == OHI_M6800) next_q.rw_wr = ~req_write; // RL7
              end else if (i2c) begin
                next_q.st       = H_SETUP;
                next_q.dc       = sa0_sel; // RL5
                next_q.oe_n     = 8'h00; // Start: data low while clock high
                next_q.shift    = {I2C_ADDR_HI, sa0_sel, 1'b0, 1'b1};
                next_q.queue    = {1'b0, req_is_data, 6'h00, req_byte};
                next_q.left     = 2'h2;
                next_q.stopping = 1'b0;
              end else begin
                next_q.st    = H_SETUP;
                next_q.cs_n  = 1'b0;
                next_q.dc    = req_is_data; // RL4
                next_q.shift = {req_byte, 1'b1};
                next_q.left  = 2'h0;
              end
            end
          end
          H_SETUP: begin
            if (!par) begin
              next_q.st = H_BIT_LO;
              next_q.drv[0] = 1'b0;
            end else begin
              next_q.st = H_STROBE;
              if (q.mode == OHI_M6800) next_q.e_rd = 1'b1; // RL6
              else if (q.wr) next_q.rw_wr = 1'b0; // RL9
              else next_q.e_rd = 1'b0; // RL8
            end
          end
          H_STROBE: begin
            if (!q.wr) begin
              next_q.resp_valid = 1'b1;
              next_q.resp_byte  = q.din_b;
            end
            next_q.e_rd  = (q.mode == OHI_M8080);
            next_q.rw_wr = (q.mode == OHI_M8080) ? 1'b1 : q.rw_wr;
            next_q.st    = H_RECOVER;
          end
          H_BIT_LO: begin
            next_q.st = H_BIT_DAT;
            if (i2c) begin
              next_q.drv[2:1]  = 2'b00;
              next_q.oe_n[2:1] = {2{q.shift[8]}}; // RL12
            end else begin
              next_q.drv[1]  = q.shift[8]; // RL11
              next_q.oe_n[1] = 1'b0;
            end
          end
          H_BIT_DAT: begin
            next_q.st     = H_BIT_HI;
            next_q.drv[0] = 1'b1;
          end
          H_BIT_HI: begin
            next_q.st     = H_BIT_LO;
            next_q.drv[0] = 1'b0;
            next_q.shift  = {q.shift[7:0], 1'b1};
            next_q.bitn   = q.bitn + 4'h1;
            if (q.stopping) begin
              next_q.st        = H_RECOVER;
              next_q.drv[0]    = 1'b1;
              next_q.oe_n[2:1] = 2'b11;
            end else if (!i2c && q.bitn == SPI_LAST) begin
              next_q.st = H_RECOVER;
            end else if (i2c && q.bitn == I2C_LAST) begin
              next_q.bitn = 4'h0;
              if (q.din_b[2] || q.left == 2'h0) begin
                // No acknowledge or last byte: one low bit, then stop
                next_q.shift    = 9'h000;
                next_q.stopping = 1'b1;
              end else begin
                next_q.shift = {q.queue[15:8], 1'b1};
                next_q.queue = {q.queue[7:0], 8'h00};
                next_q.left  = q.left - 2'h1;
              end
            end
          end
          H_RECOVER: begin
            next_q.st  = H_IDLE;
            next_q.tmr = 8'h00;
          end
          default: next_q.st = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q      <= '0;
      q.cs_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign link.link_clk          = q.lclk;
  assign link.power_on_clear_n  = q.por_n;
  assign link.chip_sel_n        = q.cs_n;
  assign link.data_cmd_sel      = q.dc;
  assign link.strobe_e_rd       = q.e_rd;
  assign link.strobe_rw_wr      = q.rw_wr;
  assign link.bus_select_first  = q.bs[0];
  assign link.bus_select_second = q.bs[1];
  assign link.host_drive        = q.drv;
  assign link.host_oe_n         = q.oe_n;
  assign req_ready              = q.ready;
  assign resp_valid             = q.resp_valid;
  assign resp_byte              = q.resp_byte;
endmodule

// ---- tb/ohi_link_assertions.sv ----
// Concurrent checks on the pins between the host end and the display end.
// Assumes clk is the host clock and rst its asynchronous active-high reset.
`timescale 1ns/1ps
module ohi_link_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Link pins
  input wire logic       power_on_clear_n,
  input wire logic       chip_sel_n,
  input wire logic       strobe_e_rd,
  input wire logic       strobe_rw_wr,
  input wire logic       bus_select_first,
  input wire logic       bus_select_second,
  input wire logic [7:0] host_data_lines,
  input wire logic [7:0] dev_oe_n
);
  import ohi_pkg::*;

  logic [1:0] bs;
  logic       ser;
  logic       rd_on;
  logic       wr_on;
  logic [5:0] rd_cnt;

  assign bs    = {bus_select_second, bus_select_first};
  assign ser   = (bs == STRAP_SPI) || (bs == STRAP_I2C);
  assign rd_on = !chip_sel_n && (((bs == STRAP_6800) && strobe_e_rd && strobe_rw_wr)
                 || ((bs == STRAP_8080) && !strobe_e_rd));
  assign wr_on = !chip_sel_n && (((bs == STRAP_6800) && strobe_e_rd && !strobe_rw_wr)
                 || ((bs == STRAP_8080) && !strobe_rw_wr));

  // Read strobe age; the display end needs a few link clocks to turn the bus round
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_cnt <= 6'h00;
    end else if (!rd_on) begin
      rd_cnt <= 6'h00;
    end else if (rd_cnt != 6'h3f) begin
      rd_cnt <= rd_cnt + 6'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_strap_hold: assert property (power_on_clear_n && $past(power_on_clear_n)
    |-> $stable(bs)) else $error("bus select changed in operation");
  chk_init_once: assert property ($past(power_on_clear_n) |-> power_on_clear_n)
    else $error("display reset pulsed again");
  chk_serial_strobes: assert property (ser && power_on_clear_n
    |-> !strobe_e_rd && !strobe_rw_wr) else $error("strobe pins not low in serial");
  chk_unused_ground: assert property (ser && power_on_clear_n
    |-> host_data_lines[7:3] == 5'h00) else $error("unused data lines not low");
  chk_spi_input_only: assert property (bs == STRAP_SPI |-> dev_oe_n == 8'hff)
    else $error("display end drives in serial mode");
  chk_i2c_sda_only: assert property (bs == STRAP_I2C |-> (dev_oe_n | 8'h04) == 8'hff)
    else $error("display end drives beyond line 2 in two-wire mode");
  chk_cs_quiet: assert property (chip_sel_n && !ser |-> dev_oe_n == 8'hff)
    else $error("display end drives while deselected");
  chk_read_drive: assert property (rd_cnt == 6'h28 |-> dev_oe_n == 8'h00)
    else $error("display end not driving during read");
  chk_write_no_drive: assert property (wr_on |-> dev_oe_n == 8'hff)
    else $error("display end drives during write");
endmodule

// ---- tb/testbench.sv ----
// Bench joining the host end and the display end through the link interface.
// Assumes the display end answers host reads with the last byte loaded on its core side.
`timescale 1ns/1ps
module testbench;
  import ohi_pkg::*;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  ohi_mode_e  mode_sel = OHI_M6800;
  logic       sa0_sel = 1'b0;
  logic       req_valid = 1'b0;
  logic       req_write = 1'b0;
  logic       req_is_data = 1'b0;
  logic [7:0] req_byte = 8'h00;
  logic [7:0] read_byte = 8'h00;
  logic       read_load = 1'b0;
  logic       req_ready;
  logic       resp_valid;
  logic [7:0] resp_byte;
  logic       out_valid;
  logic [7:0] out_byte;
  logic       out_is_data;
  logic       core_init;
  ohi_mode_e  dev_mode;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cycles = 0;

  ohi_link_if lnk ();
  ohi_host i_ohi_host (.link(lnk), .clk(clk), .rst(rst), .ce(ce), .mode_sel(mode_sel),
    .sa0_sel(sa0_sel), .req_valid(req_valid), .req_write(req_write),
    .req_is_data(req_is_data), .req_byte(req_byte), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_byte(resp_byte));
  ohi_device i_ohi_device (.link(lnk), .clk(clk), .rst(rst), .ce(ce),
    .read_byte(read_byte), .read_load(read_load), .out_valid(out_valid),
    .out_byte(out_byte), .out_is_data(out_is_data), .core_init(core_init), .mode(dev_mode));
  ohi_link_assertions u_chk (.clk(clk), .rst(rst), .power_on_clear_n(lnk.power_on_clear_n),
    .chip_sel_n(lnk.chip_sel_n), .strobe_e_rd(lnk.strobe_e_rd),
    .strobe_rw_wr(lnk.strobe_rw_wr), .bus_select_first(lnk.bus_select_first),
    .bus_select_second(lnk.bus_select_second), .host_data_lines(lnk.host_data_lines),
    .dev_oe_n(lnk.dev_oe_n));

  always #10 clk = ~clk;

  // Two-wire transfers dominate; the whole run needs roughly 22000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic start(input ohi_mode_e m, input logic a);
    int n;
    rst = 1'b1;
    mode_sel = m;
    sa0_sel = a;
    tick(3);
    rst = 1'b0;
    tick(10);
    chk({8'h00, core_init}, 9'h001);
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    // Display end captures the straps a few link clocks after its reset ends
    tick(48);
    chk({7'h00, dev_mode}, {7'h00, m});
    chk({8'h00, core_init}, 9'h000);
  endtask

  task automatic load(input logic [7:0] b);
    read_byte = b;
    read_load = 1'b1;
    tick(1);
    read_load = 1'b0;
    tick(40);
  endtask

  task automatic xfer(input logic w, input logic d, input logic [7:0] b, input logic [7:0] exp);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    req_valid = 1'b1;
    req_write = w;
    req_is_data = d;
    req_byte = b;
    tick(1);
    req_valid = 1'b0;
    n = 0;
    while ((w ? out_valid : resp_valid) !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    chk({8'h00, (w ? out_valid : resp_valid)}, 9'h001);
    if (w) chk({out_is_data, out_byte}, {d, b});
    else chk({1'b0, resp_byte}, {1'b0, exp});
  endtask

  // Serial and two-wire reads are refused with a zero byte
  initial begin
    for (int m = 0; m < 5; m++) begin
      start(m > 3 ? OHI_MI2C : ohi_mode_e'(m), m == 3);
      xfer(1'b1, 1'b0, 8'ha5, 8'h00);
      xfer(1'b1, 1'b1, 8'h3c, 8'h00);
      load(8'h96);
      xfer(1'b0, 1'b1, 8'h00, m < 2 ? 8'h96 : 8'h00);
    end
    test_done();
  end
endmodule
